// ===== rtl/cpu_bus_host.sv
// processor-side bus controller driving the interrupt and mode glue
// What this block does
// - write data driven in the same cycle as the write strobe
// - writes sample only the dma request
// - acknowledge: read lines high, strobes low
// - vector line low: wait reply, take vector, drop at end
// - dma: float bus, selects high, ordered release
// - assert-priority: data and priority strobes only
// - no-op: no strobes, requests ignored
// - cycle clock every four or three periods
// - read/write lines span address to data strobe
// - first fetch start, after halt restart
// - acknowledge only above status priority level
// - select flags encode transaction type
module cpu_bus_host
  import glue_host_pkg::*;
#(
  parameter int BUS_CLEAR_CYCLES = 4
)(
  input  wire logic               clock_in,
  input  wire logic               resetn_in,
  input  wire logic               psel_in,
  input  wire logic               penable_in,
  input  wire logic               pwrite_in,
  input  wire logic [PADDR_W-1:0] paddr_in,
  input  wire logic [31:0]        pwdata_in,
  output logic      [31:0]        prdata_out,
  output logic                    pready_out,
  output logic                    pslverr_out,
  input  wire logic [BUS_W-1:0]   local_addr_data_bus_in,
  output logic      [BUS_W-1:0]   local_addr_data_bus_out,
  output logic                    local_addr_data_bus_oe_n_out,
  output logic                    address_strobe_n_out,
  output logic                    data_strobe_n_out,
  output logic                    priority_in_strobe_n_out,
  output logic                    high_byte_read_write_out,
  output logic                    low_byte_read_write_out,
  output logic                    select_flag_zero_out,
  output logic                    select_flag_one_out,
  output logic                    processor_cycle_clock_out,
  output logic                    bus_clear_n_out,
  input  wire logic [REQ_W-1:0]   processor_request_inputs_in,
  input  wire logic               backplane_reply_n_in
);
  localparam int SYNC_W = BUS_W + REQ_W + 1;

  ctl_if ctl ();

  // ---------------- register slave ----------------
  apb_ctl_regs u_regs (
    .clock_in    (clock_in),
    .resetn_in   (resetn_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .paddr_in    (paddr_in),
    .pwdata_in   (pwdata_in),
    .prdata_out  (prdata_out),
    .pready_out  (pready_out),
    .pslverr_out (pslverr_out),
    .ctl         (ctl)
  );

  state_t            state_reg;
  state_t            state_next;
  kind_t             kind_reg;
  logic [1:0]        byte_reg;
  logic [BUS_W-1:0]  addr_reg;
  logic [BUS_W-1:0]  wdata_reg;
  logic [BUS_W-1:0]  bus_out_reg;
  logic [BUS_W-1:0]  rdata_reg;
  logic [BUS_W-1:0]  mode_reg;
  logic [REQ_W-1:0]  req_reg;
  logic [7:0]        clear_count_reg;
  logic              start_pending_reg;
  logic              restart_pending_reg;
  logic              done_reg;
  logic              refused_reg;
  logic              tick;
  logic              long_cycle;

  // ---------------- microcycle timing ----------------
  // dma and acknowledge run on the longer microcycle
  assign long_cycle = (state_reg != ST_IDLE) & (state_reg != ST_CLEAR) &
                      ((kind_reg == KIND_DMA) | (kind_reg == KIND_IAK));

  cycle_clock_gen u_clk (
    .clock_in        (clock_in),
    .resetn_in       (resetn_in),
    .long_in         (long_cycle),
    .tick_out        (tick),
    .cycle_clock_out (processor_cycle_clock_out)
  );

  // ---------------- pin synchronisers ----------------
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] sync3_reg;
  logic [SYNC_W-1:0] filt_reg;
  logic [SYNC_W-1:0] raw_pins;

  assign raw_pins = {~backplane_reply_n_in, processor_request_inputs_in, local_addr_data_bus_in};

  // three stages; stage one feeds only stage two
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= raw_pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // a bit changes only once stages two and three agree
  for (genvar i = 0; i < SYNC_W; i++) begin : g_filt
    always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
        filt_reg[i] <= 1'b0;
      end else if (sync2_reg[i] == sync3_reg[i]) begin
        filt_reg[i] <= sync3_reg[i];
      end
    end
  end

  logic [BUS_W-1:0] bus_s;
  logic [REQ_W-1:0] req_s;
  logic             reply_s;

  assign bus_s   = filt_reg[BUS_W-1:0];
  assign req_s   = filt_reg[BUS_W +: REQ_W];
  assign reply_s = filt_reg[SYNC_W-1];

  // ---------------- decoding of the pending command ----------------
  logic              is_write;
  logic              is_iak;
  logic              is_dma;
  logic              is_assert_priority_cycle;
  logic              is_nop;
  logic              is_read;
  logic              has_addr;
  logic              needs_vector;
  logic [2:0]        pending_level;
  logic              iak_ok;
  logic              accept;
  logic              refuse;
  logic [BUS_W-1:0]  start_addr;
  logic [BUS_W-1:0]  fetch_addr;
  logic [BUS_W-1:0]  iak_code;

  assign is_write = (kind_reg == KIND_WRITE);
  assign is_iak   = (kind_reg == KIND_IAK);
  assign is_dma   = (kind_reg == KIND_DMA);
  assign is_assert_priority_cycle  = (kind_reg == KIND_ASSERT_PRIORITY_CYCLE);
  assign is_nop   = (kind_reg == KIND_NOP);
  assign is_read  = (kind_reg == KIND_READ) | (kind_reg == KIND_FETCH);
  assign has_addr = is_read | is_write | is_iak;

  // vector read wanted when the coded vector line is low
  assign needs_vector = is_iak & ~req_reg[REQ_VEC];

  // acknowledge only a coded request above the status word level
  assign pending_level = irq_level(req_reg[REQ_CODE +: CODE_W]);
  assign iak_ok  = (pending_level > ctl.processor_status_word);
  assign accept  = (state_reg == ST_IDLE) & ctl.go & ((ctl.kind != KIND_IAK) | iak_ok);
  assign refuse  = (state_reg == ST_IDLE) & ctl.go & (ctl.kind == KIND_IAK) & ~iak_ok;

  // fetch address follows power-up start or post-halt restart
  assign start_addr = start_address(mode_reg[START_SEL_LSB +: 3]);
  assign fetch_addr = start_pending_reg   ? start_addr :
                      restart_pending_reg ? start_addr + RESTART_OFFSET : ctl.addr;

  // acknowledge code reproduces request inputs one to five
  assign iak_code = {3'h0, req_reg[REQ_CODE +: CODE_W], 8'h00};

  // ---------------- sequencer ----------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_CLEAR: begin
        if (tick && clear_count_reg == 8'(BUS_CLEAR_CYCLES - 1)) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (accept) begin
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tick) begin
          if (is_nop) begin
            state_next = ST_CLOSE;
          end else if (is_assert_priority_cycle) begin
            state_next = ST_STROBE;
          end else if (is_dma) begin
            state_next = ST_WAIT;
          end else begin
            state_next = ST_ADDR;
          end
        end
      end
      ST_ADDR: begin
        if (tick) begin
          state_next = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (tick) begin
          state_next = ST_PRIO;
        end
      end
      ST_PRIO: begin
        if (tick) begin
          state_next = (is_read | is_write | needs_vector) ? ST_WAIT : ST_CLOSE;
        end
      end
      ST_WAIT: begin
        // dma ends when its request drops, others on reply
        if (tick && (is_dma ? ~req_s[REQ_DMA] : reply_s)) begin
          state_next = ST_CLOSE;
        end
      end
      ST_CLOSE: begin
        if (tick) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  logic pi_release;
  logic take_data;

  assign pi_release = (state_reg == ST_PRIO) & tick;
  assign take_data  = (state_reg == ST_WAIT) & (state_next == ST_CLOSE) & ~is_dma;

  // state, bus clear count and mode word capture
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      state_reg       <= ST_CLEAR;
      clear_count_reg <= 8'h00;
      mode_reg        <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_CLEAR && tick) begin
        clear_count_reg <= clear_count_reg + 8'h01;
        mode_reg        <= bus_s;
      end
    end
  end

  // command capture at acceptance
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      kind_reg  <= KIND_NOP;
      byte_reg  <= 2'h3;
      addr_reg  <= 16'h0000;
      wdata_reg <= 16'h0000;
    end else if (accept) begin
      kind_reg  <= ctl.kind;
      byte_reg  <= ctl.byte_en;
      addr_reg  <= (ctl.kind == KIND_FETCH) ? fetch_addr : ctl.addr;
      wdata_reg <= ctl.wdata;
    end
  end

  // requests latch as the priority strobe is released
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      req_reg <= '0;
    end else if (pi_release) begin
      if (is_write) begin
        req_reg[REQ_DMA] <= req_s[REQ_DMA];
      end else begin
        req_reg <= req_s;
      end
    end
  end

  // start and restart bookkeeping; a halt request arms restart
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      start_pending_reg   <= 1'b1;
      restart_pending_reg <= 1'b0;
    end else begin
      if (accept && ctl.kind == KIND_FETCH) begin
        start_pending_reg   <= 1'b0;
        restart_pending_reg <= 1'b0;
      end
      if (pi_release && !is_write && req_s[REQ_HALT]) begin
        restart_pending_reg <= 1'b1;
      end
    end
  end

  // read data, or vector from the low byte on acknowledge
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      rdata_reg <= 16'h0000;
    end else if (take_data && !is_write) begin
      rdata_reg <= is_iak ? (bus_s & LOW_BYTE_MASK) : bus_s;
    end
  end

  // done set on completion or refusal wins over the clear by go
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      done_reg    <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      if (accept) begin
        refused_reg <= 1'b0;
      end
      if (refuse) begin
        refused_reg <= 1'b1;
      end
      if (accept) begin
        done_reg <= 1'b0;
      end
      if (refuse || (state_reg == ST_CLOSE && tick)) begin
        done_reg <= 1'b1;
      end
    end
  end

  // ---------------- bus data driver ----------------
  // address or acknowledge code first, write data in the same cycle as the strobe
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      bus_out_reg <= 16'h0000;
    end else if (state_reg == ST_SETUP && tick) begin
      bus_out_reg <= is_iak ? iak_code : addr_reg;
    end else if (state_reg == ST_ADDR && tick && is_write) begin
      bus_out_reg <= wdata_reg;
    end
  end

  logic active;
  logic drive_addr;
  logic drive_data;

  assign active     = (state_reg != ST_IDLE) & (state_reg != ST_CLEAR);
  assign drive_addr = (state_reg == ST_ADDR) & has_addr;
  assign drive_data = is_write & ((state_reg == ST_STROBE) | (state_reg == ST_PRIO) |
                                  (state_reg == ST_WAIT));

  // bus floats during bus clear so the mode word can be read
  assign local_addr_data_bus_out      = bus_out_reg;
  assign local_addr_data_bus_oe_n_out = ~(drive_addr | drive_data);
  assign bus_clear_n_out              = (state_reg != ST_CLEAR);

  // ---------------- strobes ----------------
  assign address_strobe_n_out = ~(has_addr & ((state_reg == ST_ADDR) |
                                 (state_reg == ST_STROBE) | (state_reg == ST_PRIO) |
                                 (state_reg == ST_WAIT)));
  assign data_strobe_n_out = ~((has_addr | is_assert_priority_cycle) & ((state_reg == ST_STROBE) |
                              (state_reg == ST_PRIO) | (state_reg == ST_WAIT)));
  assign priority_in_strobe_n_out = ~(~is_dma & ~is_nop & (state_reg == ST_PRIO));

  // read/write lines settle in setup, hold through close
  assign high_byte_read_write_out = ~(active & is_write & byte_reg[1]);
  assign low_byte_read_write_out  = ~(active & is_write & byte_reg[0]);

  // select flags; dma releases flag one a microcycle before flag zero
  assign select_flag_one_out  = active & (is_iak | (is_dma & (state_reg != ST_CLOSE)));
  assign select_flag_zero_out = active & (is_dma | (kind_reg == KIND_FETCH));

  // ---------------- status back to software ----------------
  assign ctl.busy    = (state_reg != ST_IDLE);
  assign ctl.done    = done_reg;
  assign ctl.refused = refused_reg;
  assign ctl.restart = restart_pending_reg;
  assign ctl.req     = req_reg;
  assign ctl.rdata   = rdata_reg;
  assign ctl.mode    = mode_reg;
  assign ctl.start   = start_addr;
endmodule

// ===== rtl/glue_host_pkg.sv
// constants, types and tables shared by the bus controller files
package glue_host_pkg;

  localparam int BUS_W   = 16;
  localparam int REQ_W   = 8;
  localparam int PADDR_W = 8;

  // register byte offsets
  localparam logic [PADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [PADDR_W-1:0] OFF_ADDR   = 8'h04;
  localparam logic [PADDR_W-1:0] OFF_WDATA  = 8'h08;
  localparam logic [PADDR_W-1:0] OFF_STATUS = 8'h0C;
  localparam logic [PADDR_W-1:0] OFF_RDATA  = 8'h10;
  localparam logic [PADDR_W-1:0] OFF_MODE   = 8'h14;
  localparam logic [PADDR_W-1:0] OFF_START  = 8'h18;

  // control word fields
  localparam int CTRL_GO   = 0;
  localparam int CTRL_KIND = 1;
  localparam int CTRL_BYTE = 4;
  localparam int CTRL_PSW  = 8;

  // status word fields
  localparam int STAT_BUSY    = 0;
  localparam int STAT_DONE    = 1;
  localparam int STAT_REFUSED = 2;
  localparam int STAT_RESTART = 3;
  localparam int STAT_REQ     = 8;

  // request input positions and acknowledge code placement on the bus
  localparam int REQ_DMA   = 0;
  localparam int REQ_CODE  = 1;
  localparam int REQ_VEC   = 5;
  localparam int REQ_POWER_FAIL_REQUEST = 6;
  localparam int REQ_HALT  = 7;
  localparam int ACK_LSB   = 8;
  localparam int CODE_W    = 5;

  // microcycle lengths in input clock periods
  localparam logic [1:0] CYCLES_SHORT = 2'h3;
  localparam logic [2:0] CYCLES_LONG  = 3'h4;

  // start select field of the mode word, restart offset and vector byte mask
  localparam int                 START_SEL_LSB  = 13;
  localparam logic [BUS_W-1:0]   RESTART_OFFSET = 16'h0004;
  localparam logic [BUS_W-1:0]   LOW_BYTE_MASK  = 16'h00FF;

  typedef enum logic [2:0] {
    KIND_READ  = 3'h0,
    KIND_FETCH = 3'h1,
    KIND_WRITE = 3'h2,
    KIND_IAK   = 3'h3,
    KIND_DMA   = 3'h4,
    KIND_ASSERT_PRIORITY_CYCLE  = 3'h5,
    KIND_NOP   = 3'h6
  } kind_t;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_CLEAR  = 8'h02,
    ST_SETUP  = 8'h04,
    ST_ADDR   = 8'h08,
    ST_STROBE = 8'h10,
    ST_PRIO   = 8'h20,
    ST_WAIT   = 8'h40,
    ST_CLOSE  = 8'h80
  } state_t;

  // jumper code to start address
  function automatic logic [BUS_W-1:0] start_address(input logic [2:0] sel);
    logic [BUS_W-1:0] a;
    a = 16'h0000;
    case (sel)
      3'h7: a = 16'hF400;
      3'h6: a = 16'hF600;
      3'h5: a = 16'h0000;
      3'h4: a = 16'h1000;
      3'h3: a = 16'h2000;
      3'h2: a = 16'h4000;
      3'h1: a = 16'h8000;
      default: a = 16'hC000;
    endcase
    return a;
  endfunction

  // coded request {vec, ai4..ai1} to priority level, zero when none
  function automatic logic [2:0] irq_level(input logic [CODE_W-1:0] code);
    logic [2:0] l;
    l = 3'h0;
    case (code)
      5'h10: l = 3'h7;
      5'h12: l = 3'h6;
      5'h11, 5'h19, 5'h15, 5'h1D: l = 3'h5;
      5'h13, 5'h1B, 5'h07: l = 3'h4;
      default: l = 3'h0;
    endcase
    return l;
  endfunction

endpackage

// ===== rtl/ctl_if.sv
// command and status carrier between the register slave and the engine
interface ctl_if;
  import glue_host_pkg::*;
  logic             go;
  kind_t            kind;
  logic [1:0]       byte_en;
  logic [2:0]       processor_status_word;
  logic [BUS_W-1:0] addr;
  logic [BUS_W-1:0] wdata;
  logic             busy;
  logic             done;
  logic             refused;
  logic             restart;
  logic [REQ_W-1:0] req;
  logic [BUS_W-1:0] rdata;
  logic [BUS_W-1:0] mode;
  logic [BUS_W-1:0] start;

  modport regs (output go, kind, byte_en, processor_status_word, addr, wdata,
                input busy, done, refused, restart, req, rdata, mode, start);
  modport engine (input go, kind, byte_en, processor_status_word, addr, wdata,
                  output busy, done, refused, restart, req, rdata, mode, start);
endinterface

// ===== rtl/cycle_clock_gen.sv
// microcycle timer: three or four input periods per cycle clock pulse
module cycle_clock_gen
  import glue_host_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic resetn_in,
  input  wire logic long_in,
  output logic      tick_out,
  output logic      cycle_clock_out
);
  logic [2:0] count_reg;
  logic [2:0] last;

  // long cycles for dma and acknowledge, short otherwise
  assign last     = long_in ? CYCLES_LONG - 3'h1 : {1'b0, CYCLES_SHORT} - 3'h1;
  assign tick_out = (count_reg >= last);

  // >= covers a switch from long to short mid-cycle
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      count_reg       <= 3'h0;
      cycle_clock_out <= 1'b0;
    end else begin
      count_reg       <= tick_out ? 3'h0 : count_reg + 3'h1;
      cycle_clock_out <= tick_out;
    end
  end
endmodule

// ===== rtl/apb_ctl_regs.sv
// apb slave holding the controller's command and status words
module apb_ctl_regs
  import glue_host_pkg::*;
(
  input  wire logic               clock_in,
  input  wire logic               resetn_in,
  input  wire logic               psel_in,
  input  wire logic               penable_in,
  input  wire logic               pwrite_in,
  input  wire logic [PADDR_W-1:0] paddr_in,
  input  wire logic [31:0]        pwdata_in,
  output logic      [31:0]        prdata_out,
  output logic                    pready_out,
  output logic                    pslverr_out,
  ctl_if.regs                     ctl
);
  logic        access;
  logic        hit;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  kind_t       kind_reg;
  logic [1:0]  byte_reg;
  logic [2:0]  psw_reg;
  logic [15:0] addr_reg;
  logic [15:0] wdata_reg;
  logic        go_reg;

  // zero wait state slave, unmapped offsets answer with an error
  assign access = psel_in & penable_in;
  assign hit = (paddr_in == OFF_CTRL) | (paddr_in == OFF_ADDR) | (paddr_in == OFF_WDATA) |
               (paddr_in == OFF_STATUS) | (paddr_in == OFF_RDATA) |
               (paddr_in == OFF_MODE) | (paddr_in == OFF_START);
  assign pready_out  = 1'b1;
  assign pslverr_out = access & ~hit;

  assign status_word = {16'h0000, ctl.req, 4'h0, ctl.restart, ctl.refused, ctl.done, ctl.busy};
  assign rd_mux = (paddr_in == OFF_CTRL)   ? {21'h0, psw_reg, 2'h0, byte_reg, kind_reg, 1'b0} :
                  (paddr_in == OFF_ADDR)   ? {16'h0000, addr_reg} :
                  (paddr_in == OFF_WDATA)  ? {16'h0000, wdata_reg} :
                  (paddr_in == OFF_STATUS) ? status_word :
                  (paddr_in == OFF_RDATA)  ? {16'h0000, ctl.rdata} :
                  (paddr_in == OFF_MODE)   ? {16'h0000, ctl.mode} :
                  (paddr_in == OFF_START)  ? {16'h0000, ctl.start} : 32'h0000_0000;
  assign prdata_out = (access & ~pwrite_in) ? rd_mux : 32'h0000_0000;

  assign ctl.go      = go_reg;
  assign ctl.kind    = kind_reg;
  assign ctl.byte_en = byte_reg;
  assign ctl.processor_status_word     = psw_reg;
  assign ctl.addr    = addr_reg;
  assign ctl.wdata   = wdata_reg;

  // writes land at the access edge; go is a one-cycle pulse
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      kind_reg  <= KIND_NOP;
      byte_reg  <= 2'h3;
      psw_reg   <= 3'h7;
      addr_reg  <= 16'h0000;
      wdata_reg <= 16'h0000;
      go_reg    <= 1'b0;
    end else begin
      go_reg <= access & pwrite_in & (paddr_in == OFF_CTRL) & pwdata_in[CTRL_GO];
      if (access & pwrite_in & (paddr_in == OFF_CTRL)) begin
        kind_reg <= kind_t'(pwdata_in[CTRL_KIND +: 3]);
        byte_reg <= pwdata_in[CTRL_BYTE +: 2];
        psw_reg  <= pwdata_in[CTRL_PSW +: 3];
      end
      if (access & pwrite_in & (paddr_in == OFF_ADDR)) begin
        addr_reg <= pwdata_in[15:0];
      end
      if (access & pwrite_in & (paddr_in == OFF_WDATA)) begin
        wdata_reg <= pwdata_in[15:0];
      end
    end
  end
endmodule

// ===== test/cpu_bus_host_asserts.sv
// pin-level checks on the bus controller
module cpu_bus_host_asserts (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic local_addr_data_bus_oe_n_out,
  input wire logic address_strobe_n_out,
  input wire logic data_strobe_n_out,
  input wire logic priority_in_strobe_n_out,
  input wire logic high_byte_read_write_out,
  input wire logic low_byte_read_write_out,
  input wire logic select_flag_zero_out,
  input wire logic select_flag_one_out,
  input wire logic processor_cycle_clock_out,
  input wire logic bus_clear_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // short names for the transaction type, bus enable and data strobe
  wire rd = high_byte_read_write_out & low_byte_read_write_out;
  wire s0 = select_flag_zero_out;
  wire s1 = select_flag_one_out;
  wire oe = local_addr_data_bus_oe_n_out;
  wire ds = data_strobe_n_out;
  chk_cycle_pulse: assert property (processor_cycle_clock_out
    |=> !processor_cycle_clock_out [*2])
    else $error("cycle clock too frequent");
  chk_dma_float: assert property (s0 && s1 |-> oe)
    else $error("bus driven during dma");
  chk_dma_release: assert property ($fell(s1) && $past(s0) |-> s0)
    else $error("select zero dropped first");
  chk_iak_read: assert property (s1 && !s0 |-> rd)
    else $error("rw low in acknowledge");
  chk_rw_steady: assert property (!address_strobe_n_out && $past(!address_strobe_n_out)
    |-> $stable(high_byte_read_write_out) && $stable(low_byte_read_write_out))
    else $error("rw lines moved");
  chk_clear_float: assert property (!bus_clear_n_out |-> oe && !s0 && !s1)
    else $error("active in bus clear");
  chk_write_drive: assert property (!ds && !rd |-> !oe)
    else $error("write strobe without data");
  chk_read_float: assert property (!ds && rd |-> oe)
    else $error("bus driven on read");
  chk_prio_strobe: assert property (!priority_in_strobe_n_out |-> !ds)
    else $error("pi outside data strobe");
  cover property (s0 && s1);
  cover property (s1 && !s0 && !ds);
  cover property (!ds && !rd);
endmodule
bind cpu_bus_host cpu_bus_host_asserts cpu_bus_host_asserts_inst (.*);

// ===== test/glue_partner.sv
// glue logic model: mode word, replies, coded requests
module glue_partner
  import glue_host_pkg::*;
#(
  parameter logic [BUS_W-1:0] MODE_WORD = 16'h8123,
  parameter logic [BUS_W-1:0] RD_WORD   = 16'hA5C4
)(
  input  wire logic             clock_in,
  input  wire logic             resetn_in,
  input  wire logic [BUS_W-1:0] bus_host_in,
  input  wire logic             oe_n_in,
  input  wire logic             ds_n_in,
  input  wire logic             rd_in,
  input  wire logic             iak_in,
  input  wire logic             bus_clear_n_in,
  input  wire logic             slow_in,
  input  wire logic             dma_in,
  input  wire logic             load_in,
  input  wire logic [4:0]       code_in,
  output logic      [BUS_W-1:0] bus_out,
  output logic                  reply_n_out,
  output logic      [REQ_W-1:0] req_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [BUS_W-1:0] last;
  logic [BUS_W-1:0] wr_word;
  logic [2:0]       wait_cnt;
  logic [4:0]       code_reg;
  // released bus shows the inverse, never a stale value
  assign bus_out = !oe_n_in ? bus_host_in : !bus_clear_n_in ? MODE_WORD
                 : (!ds_n_in && rd_in && !reply_n_out) ? RD_WORD : ~last;
  assign reply_n_out = !(!ds_n_in && wait_cnt >= (slow_in ? 3'h6 : 3'h1));
  assign req_out = {2'h0, code_reg, dma_in};
  // reply delay, write capture, request hold until acknowledged
  always_ff @(posedge clock_in) begin
    last <= bus_out;
    wait_cnt <= ds_n_in ? 3'h0 : wait_cnt + {2'h0, wait_cnt != 3'h7};
    if (!oe_n_in && (ds_n_in || !rd_in)) wr_word <= bus_host_in;
    if (!resetn_in) code_reg <= 5'h1F;
    else if (load_in) code_reg <= code_in;
    else if (iak_in && !oe_n_in) code_reg <= 5'h1F;
  end
endmodule

// ===== test/cpu_interrupt_mode_glue_tb_top.sv
// self-checking bench for the processor bus controller
module cpu_interrupt_mode_glue_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import glue_host_pkg::*;
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h want %h", $time, a, e); end end
  logic clock_in = 0, resetn_in = 0, psel = 0, penable = 0, pwrite = 0;
  logic slow = 0, dma = 0, load = 0, pready, perr, oe_n, as_n, ds_n, pi_n;
  logic hrw, lrw, s0, s1, cc, bus_clear_n, reply_n;
  logic [7:0]  paddr = 0, req;
  logic [31:0] pwdata = 0, prdata, st;
  logic [15:0] bin, bout;
  logic [4:0]  code = 0;
  int num_errors = 0, tests_run = 0;
  always #12.5 clock_in = ~clock_in;
  cpu_bus_host #(.BUS_CLEAR_CYCLES(2)) cpu_bus_host_inst (.clock_in(clock_in),
    .resetn_in(resetn_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(perr), .local_addr_data_bus_in(bin), .local_addr_data_bus_out(bout),
    .local_addr_data_bus_oe_n_out(oe_n), .address_strobe_n_out(as_n),
    .data_strobe_n_out(ds_n), .priority_in_strobe_n_out(pi_n),
    .high_byte_read_write_out(hrw), .low_byte_read_write_out(lrw),
    .select_flag_zero_out(s0), .select_flag_one_out(s1), .processor_cycle_clock_out(cc),
    .bus_clear_n_out(bus_clear_n), .processor_request_inputs_in(req),
    .backplane_reply_n_in(reply_n));
  glue_partner glue_partner_inst (.clock_in(clock_in), .resetn_in(resetn_in),
    .bus_host_in(bout), .oe_n_in(oe_n), .ds_n_in(ds_n), .rd_in(hrw & lrw),
    .iak_in(s1 & ~s0), .bus_clear_n_in(bus_clear_n), .slow_in(slow), .dma_in(dma), .load_in(load),
    .code_in(code), .bus_out(bin), .reply_n_out(reply_n), .req_out(req));
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock_in) penable <= 1;
    do @(posedge clock_in); while (pready !== 1'b1);
    q = {perr, prdata[30:0]};
    psel <= 0; penable <= 0;
    @(posedge clock_in);
  endtask
  function automatic logic [31:0] ctl(input kind_t k, input logic [2:0] p);
    return {21'h0, p, 4'h3, k, 1'b1};
  endfunction
  // start an operation, wait for busy to come and go
  task automatic op(input logic [31:0] c);
    apb(1, OFF_CTRL, c, st);
    for (int i = 0; i < 8 && st[STAT_BUSY] !== 1'b1; i++) apb(0, OFF_STATUS, 0, st);
    for (int i = 0; i < 400 && st[STAT_BUSY] !== 1'b0; i++) apb(0, OFF_STATUS, 0, st);
  endtask
  task automatic t_mode;
    apb(0, OFF_MODE, 0, st); `CHK(st, 32'h8123)
    apb(0, OFF_START, 0, st); `CHK(st, 32'h1000)
    apb(0, 8'h1C, 0, st); `CHK(st[31], 1'b1)
    op(ctl(KIND_FETCH, 7)); `CHK(glue_partner_inst.wr_word, 16'h1000)
  endtask
  task automatic t_rw;
    slow <= 1; apb(1, OFF_ADDR, 32'h1234, st); op(ctl(KIND_READ, 7));
    apb(0, OFF_RDATA, 0, st); `CHK(st, 32'hA5C4)
    slow <= 0; apb(1, OFF_WDATA, 32'h5A5A, st); op(ctl(KIND_WRITE, 7));
    `CHK(st[STAT_DONE], 1'b1)
    `CHK(glue_partner_inst.wr_word, 16'h5A5A)
  endtask
  task automatic t_dma;
    dma <= 1;
    fork op(ctl(KIND_DMA, 7));
      begin repeat (40) @(posedge clock_in); `CHK({s1, s0, oe_n}, 3'h7) dma <= 0; end
    join
    `CHK(st[STAT_DONE], 1'b1)
  endtask
  task automatic t_iak(input logic [4:0] c, input logic [2:0] p, input logic [31:0] e);
    code <= c; load <= 1; @(posedge clock_in) load <= 0;
    op(ctl(KIND_ASSERT_PRIORITY_CYCLE, 7)); `CHK(st[15:8], {2'h0, c, 1'b0})
    op(ctl(KIND_IAK, p)); `CHK(st[2], e[0])
    apb(0, OFF_RDATA, 0, st);
    if (!e[0]) `CHK({st[15:0], glue_partner_inst.code_reg}, {e[15:0], 5'h1F})
  endtask
  initial begin
    repeat (4) @(posedge clock_in);
    resetn_in <= 1;
    repeat (30) @(posedge clock_in);
    t_mode; t_rw; t_dma;
    t_iak(5'h11, 3'h7, 32'h1); t_iak(5'h11, 3'h3, 32'hA5C4); t_iak(5'h07, 3'h0, 32'h00C4);
    op(ctl(KIND_NOP, 7)); `CHK(st[STAT_DONE], 1'b1)
    conclude;
  end
  initial begin
    #750000;
    num_errors++;
    conclude;
  end
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
endmodule
